// *** design/eivp_top.sv ***
/*
  External interrupt detection and vector table placement, with an
  AHB-Lite register slave.
  Assumes the core reports global enable, instruction completion,
  vector acknowledges and the executing flash section.
*/
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module eivp_top (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic                        hready,
  input  wire logic [31:0]                 hwdata,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        ext_irq0_pin,
  input  wire logic [15:0]                 pin_change_inputs,
  input  wire logic                        cpu_global_ie,
  input  wire logic                        cpu_insn_done,
  input  wire logic [2:0]                  cpu_irq_ack,
  input  wire logic                        cpu_exec_in_boot,
  input  wire logic                        cpu_startup_busy,
  input  wire logic [1:0]                  boot_size_fuses,
  input  wire logic                        app_section_lock_bit,
  input  wire logic                        boot_section_lock_bit,
  output logic                             ext_irq0_req,
  output logic                             pin_change_irq_low,
  output logic                             pin_change_irq_high,
  output logic                             irq_blocked,
  output logic [eivp_pkg::VEC_ADDR_W-1:0]  vector_table_base,
  output logic                             wake_req
);
  import eivp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             ap_write;
    logic             ap_read;
    logic [IDX_W-1:0] ap_idx;
    logic             select;
    logic             unlock;
    logic [2:0]       ucnt;
    logic             hold;
    logic [1:0]       sense;
    logic [7:0]       enable;
    logic [7:0]       flag;
    logic [7:0]       mask_hi;
    logic [7:0]       mask_lo;
    logic             pin_s;
    logic             pin_p;
    logic [VEC_ADDR_W-1:0] vbase;
    logic [31:0]      rdata;
  } eivp_state_t;

  eivp_state_t st_ff;
  eivp_state_t nxt_st;

  logic pc_change_lo;
  logic pc_change_hi;
  logic pc_wake_lo;
  logic pc_wake_hi;

  // ----------------------------------------------------------------
  // Pin-change groups
  // ----------------------------------------------------------------
  eivp_pc_group u_grp_lo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (pin_change_inputs[7:0]),
    .mask    (st_ff.mask_lo),
    .change  (pc_change_lo),
    .wake    (pc_wake_lo)
  );

  eivp_pc_group u_grp_hi (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (pin_change_inputs[15:8]),
    .mask    (st_ff.mask_hi),
    .change  (pc_change_hi),
    .wake    (pc_wake_hi)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       ap_valid;
  logic       wr_mcu;
  logic       wr_sense;
  logic       wr_enable;
  logic       wr_flag;
  logic       wr_mask_hi;
  logic       wr_mask_lo;
  logic [7:0] wbyte;

  assign ap_valid   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wbyte      = hwdata[7:0];
  assign wr_mcu     = st_ff.ap_write && (st_ff.ap_idx == IDX_MCU_CONTROL);
  assign wr_sense   = st_ff.ap_write && (st_ff.ap_idx == IDX_SENSE_CTRL);
  assign wr_enable  = st_ff.ap_write && (st_ff.ap_idx == IDX_IRQ_ENABLE);
  assign wr_flag    = st_ff.ap_write && (st_ff.ap_idx == IDX_IRQ_FLAG);
  assign wr_mask_hi = st_ff.ap_write && (st_ff.ap_idx == IDX_PC_MASK_HI);
  assign wr_mask_lo = st_ff.ap_write && (st_ff.ap_idx == IDX_PC_MASK_LO);

  // ----------------------------------------------------------------
  // External pin triggers
  // ----------------------------------------------------------------
  logic ext_edge;
  logic level_mode;

  assign level_mode = (st_ff.sense == EIVP_SENSE_LOW);

  // Registered samples keep edges clean; one-clock pulses are caught
  always_comb begin
    unique case (eivp_sense_t'(st_ff.sense))
      EIVP_SENSE_LOW:  ext_edge = 1'b0;
      EIVP_SENSE_ANY:  ext_edge = st_ff.pin_s ^ st_ff.pin_p;
      EIVP_SENSE_FALL: ext_edge = st_ff.pin_p && !st_ff.pin_s;
      EIVP_SENSE_RISE: ext_edge = !st_ff.pin_p && st_ff.pin_s;
    endcase
  end

  // ----------------------------------------------------------------
  // Blocking and suppression
  // ----------------------------------------------------------------
  logic lock_mute;
  logic block_all;
  logic gate;

  // Boot vectors with app lock mute app code, and the reverse
  assign lock_mute = (st_ff.select && app_section_lock_bit && !cpu_exec_in_boot)
                  || (!st_ff.select && boot_section_lock_bit && cpu_exec_in_boot);

  assign block_all = st_ff.unlock || st_ff.hold;

  // Global enable is only read here, never written back
  assign gate = cpu_global_ie && !block_all && !lock_mute;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Address phase capture
    nxt_st.ap_write = ap_valid && hwrite;
    nxt_st.ap_read  = ap_valid && !hwrite;
    nxt_st.ap_idx   = haddr[IDX_W+1:2];

    // Pin sampling, independent of the pin's direction
    nxt_st.pin_s = ext_irq0_pin;
    nxt_st.pin_p = st_ff.pin_s;

    // Unlock window countdown
    if (st_ff.unlock) begin
      if (st_ff.ucnt == 3'h0) begin
        nxt_st.unlock = 1'b0;
      end else begin
        nxt_st.ucnt = st_ff.ucnt - 3'h1;
      end
    end

    // Hold ends once the instruction after the select write retires
    if (st_ff.hold && cpu_insn_done) begin
      nxt_st.hold = 1'b0;
    end

    if (wr_mcu) begin
      if (wbyte[BIT_UNLOCK]) begin
        // A new unlock restarts the window; select is left alone
        nxt_st.unlock = 1'b1;
        nxt_st.ucnt   = UNLOCK_CNT_LOAD;
      end else if (st_ff.unlock) begin
        nxt_st.select = wbyte[BIT_SELECT];
        nxt_st.unlock = 1'b0;
        nxt_st.hold   = 1'b1;
      end
    end

    if (wr_sense) begin
      nxt_st.sense = wbyte[1:0];
    end
    if (wr_enable) begin
      nxt_st.enable = wbyte & 8'hC1;
    end
    if (wr_mask_hi) begin
      nxt_st.mask_hi = wbyte;
    end
    if (wr_mask_lo) begin
      nxt_st.mask_lo = wbyte;
    end

    // Clears first (write-one or vector acknowledge), then sets win
    if (wr_flag) begin
      nxt_st.flag = st_ff.flag & ~(wbyte & 8'hC1);
    end
    if (cpu_irq_ack[0]) begin
      nxt_st.flag[BIT_EXT0] = 1'b0;
    end
    if (cpu_irq_ack[1]) begin
      nxt_st.flag[BIT_PC_LOW] = 1'b0;
    end
    if (cpu_irq_ack[2]) begin
      nxt_st.flag[BIT_PC_HIGH] = 1'b0;
    end
    if (ext_edge) begin
      nxt_st.flag[BIT_EXT0] = 1'b1;
    end
    if (pc_change_lo) begin
      nxt_st.flag[BIT_PC_LOW] = 1'b1;
    end
    if (pc_change_hi) begin
      nxt_st.flag[BIT_PC_HIGH] = 1'b1;
    end
    if (nxt_st.sense == EIVP_SENSE_LOW) begin
      nxt_st.flag[BIT_EXT0] = 1'b0;
    end

    // Vector base follows the select bit and the boot size fuses
    if (nxt_st.select) begin
      unique case (boot_size_fuses)
        2'b00: nxt_st.vbase = BOOT_START_SZ0;
        2'b01: nxt_st.vbase = BOOT_START_SZ1;
        2'b10: nxt_st.vbase = BOOT_START_SZ2;
        2'b11: nxt_st.vbase = BOOT_START_SZ3;
      endcase
    end else begin
      nxt_st.vbase = APP_VECTOR_BASE;
    end

    // Read data from next values so a write then read sees new data
    nxt_st.rdata = 32'h0000_0000;
    if (ap_valid && !hwrite) begin
      unique case (haddr[IDX_W+1:2])
        IDX_MCU_CONTROL: nxt_st.rdata[7:0] = {6'h00, nxt_st.select, nxt_st.unlock};
        IDX_SENSE_CTRL:  nxt_st.rdata[7:0] = {6'h00, nxt_st.sense};
        IDX_IRQ_ENABLE:  nxt_st.rdata[7:0] = nxt_st.enable;
        IDX_IRQ_FLAG:    nxt_st.rdata[7:0] = nxt_st.flag;
        IDX_PC_MASK_HI:  nxt_st.rdata[7:0] = nxt_st.mask_hi;
        IDX_PC_MASK_LO:  nxt_st.rdata[7:0] = nxt_st.mask_lo;
        default:         nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff         <= '0;
      st_ff.select  <= RST_MCU_CONTROL[BIT_SELECT];
      st_ff.unlock  <= RST_MCU_CONTROL[BIT_UNLOCK];
      st_ff.sense   <= RST_SENSE;
      st_ff.enable  <= RST_ENABLE;
      st_ff.flag    <= RST_FLAG;
      st_ff.mask_hi <= RST_MASK;
      st_ff.mask_lo <= RST_MASK;
      st_ff.pin_s   <= 1'b1;
      st_ff.pin_p   <= 1'b1;
      st_ff.vbase   <= APP_VECTOR_BASE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic level_req;

  // Level request follows the sampled pin; none while still starting up
  assign level_req = level_mode && !st_ff.pin_s && !cpu_startup_busy;

  assign ext_irq0_req        = gate && st_ff.enable[BIT_EXT0]
                             && (st_ff.flag[BIT_EXT0] || level_req);
  assign pin_change_irq_low  = gate && st_ff.enable[BIT_PC_LOW]
                             && st_ff.flag[BIT_PC_LOW];
  assign pin_change_irq_high = gate && st_ff.enable[BIT_PC_HIGH]
                             && st_ff.flag[BIT_PC_HIGH];
  assign irq_blocked         = block_all;
  assign vector_table_base   = st_ff.vbase;

  // Clockless wake: low level and pin change only; edges need the clock
  assign wake_req = (st_ff.enable[BIT_EXT0] && level_mode && !ext_irq0_pin)
                 || (st_ff.enable[BIT_PC_LOW] && pc_wake_lo)
                 || (st_ff.enable[BIT_PC_HIGH] && pc_wake_hi);

  assign hrdata    = st_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // eivp_top

// *** design/eivp_pkg.sv ***
/*
  Constants, register map and field layout of the external interrupt
  front end with vector table placement.
  Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
*/
package eivp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 10;
  localparam logic [9:0] IDX_MCU_CONTROL = 10'h040;
  localparam logic [9:0] IDX_SENSE_CTRL  = 10'h041;
  localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h042;
  localparam logic [9:0] IDX_IRQ_FLAG    = 10'h03C;
  localparam logic [9:0] IDX_PC_MASK_HI  = 10'h06C;
  localparam logic [9:0] IDX_PC_MASK_LO  = 10'h06B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_UNLOCK  = 0;
  localparam int unsigned BIT_SELECT  = 1;
  localparam int unsigned BIT_EXT0    = 0;
  localparam int unsigned BIT_PC_LOW  = 6;
  localparam int unsigned BIT_PC_HIGH = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
  localparam logic [1:0] RST_SENSE       = 2'h0;
  localparam logic [7:0] RST_ENABLE      = 8'h00;
  localparam logic [7:0] RST_FLAG        = 8'h00;
  localparam logic [7:0] RST_MASK        = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned UNLOCK_WINDOW_CYC = 4;
  localparam logic [2:0]  UNLOCK_CNT_LOAD   = 3'(UNLOCK_WINDOW_CYC - 1);

  // ----------------------------------------------------------------
  // Sense modes and boot section start (word address)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EIVP_SENSE_LOW  = 2'b00,
    EIVP_SENSE_ANY  = 2'b01,
    EIVP_SENSE_FALL = 2'b10,
    EIVP_SENSE_RISE = 2'b11
  } eivp_sense_t;

  localparam int unsigned VEC_ADDR_W = 13;
  localparam logic [12:0] APP_VECTOR_BASE = 13'h0000;
  localparam logic [12:0] BOOT_START_SZ0  = 13'h1800;
  localparam logic [12:0] BOOT_START_SZ1  = 13'h1C00;
  localparam logic [12:0] BOOT_START_SZ2  = 13'h1E00;
  localparam logic [12:0] BOOT_START_SZ3  = 13'h1F00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage : eivp_pkg

// *** design/eivp_pc_group.sv ***
/*
  One group of eight pin-change inputs: masked toggle detection.
  Assumes pins are synchronous to hclk; wake path is combinational.
*/
`timescale 1ns/10ps
module eivp_pc_group (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] mask,
  output logic            change,
  output logic            wake
);
  import eivp_pkg::*;

  typedef struct packed {
    logic [7:0] sample;
    logic [7:0] prev;
  } eivp_grp_state_t;

  eivp_grp_state_t st_ff;
  eivp_grp_state_t nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.sample = pins;
    nxt_st.prev   = st_ff.sample;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Clocked set path compares two successive samples
  assign change = |((st_ff.sample ^ st_ff.prev) & mask);

  // Raw pin against last sample; works with the clock stopped
  assign wake = |((pins ^ st_ff.sample) & mask);

endmodule // eivp_pc_group

// *** tb/eivp_checker_asserts.sv ***
/*
  Concurrent checks on the ports of eivp_top.
  Assumes a single hclk domain and hready tied to hreadyout by the bench.
*/
`timescale 1ns/10ps
module eivp_checker
  import eivp_pkg::*;
(
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic                        cpu_global_ie,
  input wire logic                        cpu_exec_in_boot,
  input wire logic [1:0]                  boot_size_fuses,
  input wire logic                        app_section_lock_bit,
  input wire logic                        boot_section_lock_bit,
  input wire logic                        ext_irq0_req,
  input wire logic                        pin_change_irq_low,
  input wire logic                        pin_change_irq_high,
  input wire logic                        irq_blocked,
  input wire logic [eivp_pkg::VEC_ADDR_W-1:0] vector_table_base
);
  import eivp_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        wr_mcu_ff;
  logic        any_req;
  logic [12:0] boot_base;
  assign any_req = ext_irq0_req | pin_change_irq_low | pin_change_irq_high;
  always_comb begin
    case (boot_size_fuses)
      2'h0:    boot_base = BOOT_START_SZ0;
      2'h1:    boot_base = BOOT_START_SZ1;
      2'h2:    boot_base = BOOT_START_SZ2;
      default: boot_base = BOOT_START_SZ3;
    endcase
  end
  // High during the data phase of a write to the control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_mcu_ff <= 1'b0;
    end else begin
      wr_mcu_ff <= hsel && hready && htrans[1] && hwrite && (haddr[11:2] == IDX_MCU_CONTROL);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("slave not ready or not okay");
  a_base_value: assert property (vector_table_base == APP_VECTOR_BASE ||
    vector_table_base == boot_base) else $error("vector base not a legal start");
  a_req_gated: assert property (any_req |-> cpu_global_ie && !irq_blocked)
    else $error("request while globally disabled or blocked");
  a_lock_mute: assert property (((vector_table_base != APP_VECTOR_BASE) &&
    app_section_lock_bit && !cpu_exec_in_boot) || ((vector_table_base == APP_VECTOR_BASE) &&
    boot_section_lock_bit && cpu_exec_in_boot) |-> !any_req) else $error("lock mute ignored");
  a_unlock_block: assert property (!irq_blocked && wr_mcu_ff && hwdata[0] |=>
    irq_blocked[*2]) else $error("unlock did not block");
  a_unlock_expire: assert property (!irq_blocked && wr_mcu_ff && hwdata[0] ##1
    (!wr_mcu_ff)[*4] |-> $past(irq_blocked, 3) && irq_blocked ##1 !irq_blocked)
    else $error("unlock window not four cycles");
  a_base_on_write: assert property ($changed(vector_table_base) |-> $past(wr_mcu_ff))
    else $error("vector base moved without a write");
  a_select_refused: assert property (!irq_blocked && wr_mcu_ff && !hwdata[0] |=>
    $stable(vector_table_base)) else $error("select taken without unlock");
endmodule // eivp_checker

// *** tb/eivp_core_model.sv ***
/*
  Behavioural core: retires an instruction every fourth cycle and
  takes pending vectors, promptly or slowly.
  Assumes the request outputs of eivp_top as its inputs.
*/
`timescale 1ns/10ps
module eivp_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ack_en,
  input  wire logic       slow,
  input  wire logic       ext_irq0_req,
  input  wire logic       pin_change_irq_low,
  input  wire logic       pin_change_irq_high,
  output logic            cpu_insn_done,
  output logic [2:0]      cpu_irq_ack
);
  logic [1:0] insn_ff;
  logic [2:0] dly_ff;
  logic [2:0] reqs;
  assign reqs = {pin_change_irq_high, pin_change_irq_low, ext_irq0_req};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insn_ff       <= 2'h0;
      cpu_insn_done <= 1'b0;
      cpu_irq_ack   <= 3'h0;
      dly_ff        <= 3'h0;
    end else begin
      insn_ff       <= insn_ff + 2'h1;
      cpu_insn_done <= (insn_ff == 2'h3);
      cpu_irq_ack   <= 3'h0;
      // Reload the latency while idle so each vector waits afresh
      if (!ack_en || reqs == 3'h0 || cpu_irq_ack != 3'h0) begin
        dly_ff <= slow ? 3'h5 : 3'h1;
      end else if (dly_ff != 3'h0) begin
        dly_ff <= dly_ff - 3'h1;
      end else begin
        cpu_irq_ack <= reqs & ~(reqs - 3'h1);
      end
    end
  end
endmodule // eivp_core_model

// *** tb/eivp_tb_top.sv ***
/*
  Self-checking bench for eivp_top: AHB-Lite master tasks, pin stimulus
  and the core model. Assumes a 100 MHz hclk and zero-wait slave.
*/
`timescale 1ns/10ps
module eivp_tb_top;
  import eivp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, ext_pin, gie, exec_boot, busy;
  logic        app_lock, boot_lock, ack_en, slow, insn_done, hreadyout, hresp;
  logic        plo, phi, ereq, blocked, wake, old, nv, elo, ehi;
  logic [1:0]  htrans, fuses, m;
  logic [2:0]  ack;
  logic [7:0]  mlo, mhi;
  logic [12:0] base;
  logic [15:0] pcin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_errors, compares, p;
  localparam logic [9:0] IDXS [7] = '{IDX_MCU_CONTROL, IDX_SENSE_CTRL, IDX_IRQ_ENABLE,
    IDX_IRQ_FLAG, IDX_PC_MASK_HI, IDX_PC_MASK_LO, 10'h3FF};
  eivp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq0_pin(ext_pin),
    .pin_change_inputs(pcin), .cpu_global_ie(gie), .cpu_insn_done(insn_done),
    .cpu_irq_ack(ack), .cpu_exec_in_boot(exec_boot), .cpu_startup_busy(busy),
    .boot_size_fuses(fuses), .app_section_lock_bit(app_lock),
    .boot_section_lock_bit(boot_lock), .ext_irq0_req(ereq), .pin_change_irq_low(plo),
    .pin_change_irq_high(phi), .irq_blocked(blocked), .vector_table_base(base),
    .wake_req(wake));
  eivp_core_model u_core (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en), .slow(slow),
    .ext_irq0_req(ereq), .pin_change_irq_low(plo), .pin_change_irq_high(phi),
    .cpu_insn_done(insn_done), .cpu_irq_ack(ack));
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  // Entered just after a rising edge; returns at the data-phase edge
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
    rd = hrdata;
    if (k >= 40) begin n_errors++; stop_test(); end
  endtask
  function automatic logic trig(input logic [1:0] md, input logic a, input logic b);
    case (md)
      EIVP_SENSE_ANY:  return a != b;
      EIVP_SENSE_FALL: return a && !b;
      EIVP_SENSE_RISE: return !a && b;
      default:         return 1'b0;
    endcase
  endfunction
  function automatic logic [31:0] bstart(input logic [1:0] f);
    logic [12:0] s [4];
    s = '{BOOT_START_SZ0, BOOT_START_SZ1, BOOT_START_SZ2, BOOT_START_SZ3};
    return {19'h0, s[f]};
  endfunction
  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    stop_test();
  end
  initial begin
    {hresetn, hsel, hwrite, gie, exec_boot, busy, app_lock, boot_lock, ack_en} = '0;
    {haddr, hwdata, htrans, pcin, n_errors, compares} = '0;
    ext_pin = 1'b1;
    slow = 1'b1;
    gie = 1'b1;
    void'($urandom(13171));
    fuses = 2'($urandom);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 10'h3FF, 8'hFF);
    foreach (IDXS[i]) begin
      bus(1'b0, IDXS[i], 8'h00);
      chk32("reset or unmapped", 32'h0, rd);
    end
    bus(1'b1, IDX_IRQ_ENABLE, 8'hC1);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      bus(1'b1, IDX_SENSE_CTRL, {6'h0, m});
      for (int t = 0; t < 2; t++) begin
        bus(1'b1, IDX_IRQ_FLAG, 8'h01);
        old = ext_pin;
        nv = ~ext_pin;
        ext_pin <= nv;
        repeat (4) @(posedge hclk);
        bus(1'b0, IDX_IRQ_FLAG, 8'h00);
        chk1("ext flag", trig(m, old, nv), rd[0]);
        if (m == EIVP_SENSE_LOW && !nv) begin
          chk1("level req", 1'b1, ereq);
          chk1("level wake", 1'b1, wake);
          busy <= 1'b1;
          @(posedge hclk);
          chk1("start-up req", 1'b0, ereq);
          busy <= 1'b0;
          gie <= 1'b0;
          @(posedge hclk);
          chk1("global off req", 1'b0, ereq);
          gie <= 1'b1;
        end
      end
    end
    mlo = 8'($urandom) | 8'h01;
    mhi = 8'($urandom);
    bus(1'b1, IDX_PC_MASK_LO, mlo);
    bus(1'b1, IDX_PC_MASK_HI, mhi);
    bus(1'b0, IDX_PC_MASK_LO, 8'h00);
    chk32("mask low", {24'h0, mlo}, rd);
    for (int k = 0; k < 14; k++) begin
      p = (k < 2) ? k * 8 : int'($urandom % 16);
      bus(1'b1, IDX_IRQ_FLAG, 8'hC1);
      pcin[p] <= ~pcin[p];
      elo = (p < 8) && mlo[p % 8];
      ehi = (p >= 8) && mhi[p % 8];
      #1 chk1("pc wake", elo | ehi, wake);
      repeat (4) @(posedge hclk);
      bus(1'b0, IDX_IRQ_FLAG, 8'h00);
      chk1("pc flag low", elo, rd[BIT_PC_LOW]);
      chk1("pc flag high", ehi, rd[BIT_PC_HIGH]);
      chk1("pc req low", elo, plo);
      chk1("pc req high", ehi, phi);
    end
    ack_en <= 1'b1;
    pcin[0] <= ~pcin[0];
    repeat (14) @(posedge hclk);
    bus(1'b0, IDX_IRQ_FLAG, 8'h00);
    chk1("vectored flag", 1'b0, rd[BIT_PC_LOW]);
    ack_en <= 1'b0;
    pcin[0] <= ~pcin[0];
    repeat (4) @(posedge hclk);
    bus(1'b1, IDX_MCU_CONTROL, 8'h02);
    #1 chk32("base refused", 32'h0, {19'h0, base});
    bus(1'b1, IDX_MCU_CONTROL, 8'h01);
    #1 chk1("blocked", 1'b1, blocked);
    chk1("blocked req", 1'b0, plo);
    bus(1'b1, IDX_MCU_CONTROL, 8'h02);
    #1 chk32("base boot", bstart(fuses), {19'h0, base});
    bus(1'b0, IDX_MCU_CONTROL, 8'h00);
    chk32("control", 32'h2, rd);
    repeat (8) @(posedge hclk);
    app_lock <= 1'b1;
    #1 chk1("app mute", 1'b0, plo);
    exec_boot <= 1'b1;
    #1 chk1("boot runs", 1'b1, plo);
    app_lock <= 1'b0;
    bus(1'b1, IDX_MCU_CONTROL, 8'h01);
    repeat (6) @(posedge hclk);
    #1 chk1("window over", 1'b0, blocked);
    bus(1'b0, IDX_MCU_CONTROL, 8'h00);
    chk32("unlock cleared", 32'h2, rd);
    bus(1'b1, IDX_MCU_CONTROL, 8'h01);
    bus(1'b1, IDX_MCU_CONTROL, 8'h00);
    #1 chk32("base app", 32'h0, {19'h0, base});
    repeat (8) @(posedge hclk);
    boot_lock <= 1'b1;
    #1 chk1("boot mute", 1'b0, plo);
    stop_test();
  end
endmodule // eivp_tb_top

bind eivp_top eivp_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .cpu_global_ie(cpu_global_ie),
  .cpu_exec_in_boot(cpu_exec_in_boot), .boot_size_fuses(boot_size_fuses),
  .app_section_lock_bit(app_section_lock_bit), .boot_section_lock_bit(boot_section_lock_bit),
  .ext_irq0_req(ext_irq0_req), .pin_change_irq_low(pin_change_irq_low),
  .pin_change_irq_high(pin_change_irq_high), .irq_blocked(irq_blocked),
  .vector_table_base(vector_table_base));
